/* common/eeprom_defines.svh */
// Constants of the serial EEPROM command core
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

`define EE_WORD_W 16
`define EE_ADDR_W 8
`define EE_OPC_W 3
`define EE_CNT_W 5
`define EE_SYNC_W 4

`define EE_OPC_PDS 3'h0
`define EE_OPC_PROG 3'h1
`define EE_OPC_READ 3'h2
`define EE_OPC_PEN 3'h3
`define EE_OPC_WRITE_ALL_CMD 3'h4
`define EE_OPC_ERASE_ALL_CMD 3'h5

`define EE_CLK_HZ 40000000
`define EE_WRITE_TIME_MS 5
`define EE_WRITE_MAX_MS 10
`define EE_MS_PER_S 1000

`endif

/* common/eeprom_pkg.sv */
// Types of the serial EEPROM command core
package eeprom_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPC,
      ST_ADDR,
      ST_DATA,
      ST_READ,
      ST_DONE,
      ST_BUSY
   } cmd_state_type;
endpackage

/* design/pin_sync.sv */
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

/* design/serial_eeprom_command_core.sv */
// Command and write-control core of a 16-bit-word serial EEPROM
//
// Contract
// [RULE1] Read shifts addressed word out on falling edges
// [RULE2] Continued clocks read the next word
// [RULE3] Read address wraps from all ones to zero
// [RULE4] Writes start when chip select falls
// [RULE5] Write cycle takes under ten milliseconds
// [RULE6] Data out low while busy, high after
// [RULE7] Host may poll completion repeatedly
// [RULE8] Clock and data ignored during write cycle
// [RULE9] Start bit returns data out to high impedance
// [RULE10] Host holds data in low while polling
// [RULE11] Program keeps last sixteen data bits
// [RULE12] No prior erase needed before writing
// [RULE13] Write-all stores one word everywhere
// [RULE14] Erase-all sets every bit to one
// [RULE15] Enable latch gates all write commands
// [RULE16] Enable latch cleared at power-on
// [RULE17] Host keeps device write-disabled when idle
// [RULE18] Protect low blocks writes to lower half
// [RULE19] Protected write still runs full cycle
// [RULE20] Host keeps protect steady during writes
// [RULE21] Start bit is data in high on rise
// [RULE22] Verify output only after write commands
// [RULE23] Sample on rising, output on falling edge
// [RULE24] Chip select low idles and ends command
// [RULE25] Start, opcode and address form command frame
// [RULE26] Opcodes and address width chosen to fit
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module serial_eeprom_command_core
   import eeprom_pkg::*;
#(
   parameter int ADDR_W = `EE_ADDR_W,
   parameter int WORD_W = `EE_WORD_W,
   parameter int WRITE_CYCLES =
      `EE_WRITE_TIME_MS * (`EE_CLK_HZ / `EE_MS_PER_S)
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic chip_select,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   input wire logic protect_in,
   output logic data_out,
   output logic data_out_oe_n
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int TW = $clog2(WRITE_CYCLES + 1);
   localparam int BW = $clog2(WORD_W);
   localparam int MAX_CYCLES =
      `EE_WRITE_MAX_MS * (`EE_CLK_HZ / `EE_MS_PER_S);

   // Synchronised pins
   logic [`EE_SYNC_W-1:0] pins_s;
   logic cs_s;
   logic sk_s;
   logic di_s;
   logic prot_s;

   pin_sync #(
      .WIDTH(`EE_SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({chip_select, serial_clock_in, serial_data_in,
                 protect_in}),
      .sync_out(pins_s)
   );

   assign cs_s = pins_s[3];
   assign sk_s = pins_s[2];
   assign di_s = pins_s[1];
   assign prot_s = pins_s[0];

   // State
   cmd_state_type st_ff;
   cmd_state_type nxt_st;
   logic sk_prev_ff;
   logic cs_prev_ff;
   logic [`EE_OPC_W-1:0] opc_ff;
   logic [`EE_OPC_W-1:0] nxt_opc;
   logic [ADDR_W-1:0] addr_ff;
   logic [ADDR_W-1:0] nxt_addr;
   logic [WORD_W-1:0] wdata_ff;
   logic [WORD_W-1:0] nxt_wdata;
   logic [`EE_CNT_W-1:0] cnt_ff;
   logic [`EE_CNT_W-1:0] nxt_cnt;
   logic [BW-1:0] rbit_ff;
   logic [BW-1:0] nxt_rbit;
   logic rd_drive_ff;
   logic nxt_rd_drive;
   logic wel_ff;
   logic nxt_wel;
   logic verify_ff;
   logic nxt_verify;
   logic prot_ff;
   logic all_ff;
   logic sweep_on_ff;
   logic [ADDR_W-1:0] sweep_addr_ff;
   logic [TW-1:0] tmr_ff;
   logic data_out_ff;
   logic oe_n_ff;
   logic [WORD_W-1:0] mem_ff [DEPTH];

   // Edge and command decode
   logic sk_rise;
   logic sk_fall;
   logic cs_fall;
   logic busy;
   logic opc_done;
   logic addr_done;
   logic data_full;
   logic write_ready;
   logic launch;
   logic start_seen;
   logic wr_en_w;
   logic sweep_last;
   logic [WORD_W-1:0] rd_word;

   function automatic logic is_data_cmd(input logic [`EE_OPC_W-1:0] op);
      is_data_cmd = (op == `EE_OPC_PROG) || (op == `EE_OPC_WRITE_ALL_CMD);
   endfunction

   assign sk_rise = sk_s & ~sk_prev_ff;
   assign sk_fall = ~sk_s & sk_prev_ff;
   assign cs_fall = ~cs_s & cs_prev_ff;
   assign busy = (st_ff == ST_BUSY);
   assign opc_done = (cnt_ff == `EE_CNT_W'(`EE_OPC_W - 1));
   assign addr_done = (cnt_ff == `EE_CNT_W'(ADDR_W - 1));
   assign data_full = (cnt_ff == `EE_CNT_W'(WORD_W));
   assign start_seen = (st_ff == ST_IDLE) & cs_s & sk_rise & di_s; // [RULE21]
   // Writes launch only on chip select falling with a complete frame
   assign write_ready = ((st_ff == ST_DATA) & data_full &
                         is_data_cmd(opc_ff)) |
                        ((st_ff == ST_DONE) &
                         (opc_ff == `EE_OPC_ERASE_ALL_CMD)); // [RULE4]
   assign launch = cs_fall & write_ready & wel_ff; // [RULE15]
   assign rd_word = mem_ff[addr_ff];
   // Protect low blocks the half starting at address zero
   assign wr_en_w = busy & sweep_on_ff &
                    (prot_ff | sweep_addr_ff[ADDR_W-1]); // [RULE18]
   assign sweep_last = ~all_ff | (&sweep_addr_ff);

   // Command sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_opc = opc_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_cnt = cnt_ff;
      nxt_rbit = rbit_ff;
      nxt_rd_drive = rd_drive_ff;
      nxt_wel = wel_ff;
      nxt_verify = verify_ff;
      case (st_ff)
         ST_BUSY: begin
            // Pins are not looked at until the cycle ends
            if (tmr_ff == '0) begin // [RULE8]
               nxt_st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (start_seen) begin
               nxt_st = ST_OPC;
               nxt_cnt = '0;
               nxt_verify = 1'h0; // [RULE9] [RULE10]
            end
         end
         ST_OPC: begin
            if (sk_rise) begin // [RULE23]
               nxt_opc = {opc_ff[`EE_OPC_W-2:0], di_s}; // [RULE25]
               nxt_cnt = opc_done ? '0 : cnt_ff + `EE_CNT_W'(1);
               if (opc_done) begin
                  nxt_st = ST_ADDR;
               end
            end
         end
         ST_ADDR: begin
            if (sk_rise) begin
               nxt_addr = {addr_ff[ADDR_W-2:0], di_s}; // [RULE26]
               nxt_cnt = addr_done ? '0 : cnt_ff + `EE_CNT_W'(1);
               if (addr_done) begin
                  case (opc_ff)
                     `EE_OPC_READ: begin
                        nxt_st = ST_READ; // [RULE1]
                        nxt_rbit = BW'(WORD_W - 1);
                        nxt_rd_drive = 1'h0;
                     end
                     `EE_OPC_PROG, `EE_OPC_WRITE_ALL_CMD: begin
                        nxt_st = ST_DATA;
                     end
                     `EE_OPC_PEN: begin
                        nxt_st = ST_DONE;
                        nxt_wel = 1'h1; // [RULE15]
                     end
                     `EE_OPC_PDS: begin
                        nxt_st = ST_DONE;
                        nxt_wel = 1'h0; // [RULE15]
                     end
                     default: begin
                        nxt_st = ST_DONE;
                     end
                  endcase
               end
            end
         end
         ST_DATA: begin
            if (sk_rise) begin
               // Overflow keeps shifting; the last word wins
               nxt_wdata = {wdata_ff[WORD_W-2:0], di_s}; // [RULE11]
               nxt_cnt = data_full ? cnt_ff : cnt_ff + `EE_CNT_W'(1);
            end
         end
         ST_READ: begin
            if (sk_fall) begin // [RULE23]
               nxt_rd_drive = 1'h1;
               nxt_rbit = rbit_ff - BW'(1);
               if (rbit_ff == '0) begin
                  // Next word follows; address wraps at the top
                  nxt_addr = addr_ff + ADDR_W'(1); // [RULE2] [RULE3]
               end
            end
         end
         ST_DONE: begin
            nxt_st = ST_DONE;
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
      if (!busy && !cs_s) begin
         nxt_st = launch ? ST_BUSY : ST_IDLE; // [RULE24]
         nxt_rd_drive = 1'h0;
      end
      if (launch) begin
         nxt_verify = 1'h1; // [RULE22]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= ST_IDLE;
         opc_ff <= '0;
         addr_ff <= '0;
         wdata_ff <= '0;
         cnt_ff <= '0;
         rbit_ff <= '0;
         rd_drive_ff <= 1'h0;
         wel_ff <= 1'h0; // [RULE16]
         verify_ff <= 1'h0;
      end else begin
         st_ff <= nxt_st;
         opc_ff <= nxt_opc;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         cnt_ff <= nxt_cnt;
         rbit_ff <= nxt_rbit;
         rd_drive_ff <= nxt_rd_drive;
         wel_ff <= nxt_wel;
         verify_ff <= nxt_verify;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sk_prev_ff <= 1'h0;
         cs_prev_ff <= 1'h0;
      end else begin
         sk_prev_ff <= sk_s;
         cs_prev_ff <= cs_s;
      end
   end

   // Write cycle timer and array sweep
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tmr_ff <= '0;
         prot_ff <= 1'h0;
         all_ff <= 1'h0;
         sweep_on_ff <= 1'h0;
         sweep_addr_ff <= '0;
      end else if (launch) begin
         tmr_ff <= TW'(WRITE_CYCLES - 1); // [RULE5] [RULE19]
         prot_ff <= prot_s; // [RULE20]
         all_ff <= (opc_ff != `EE_OPC_PROG); // [RULE13] [RULE14]
         sweep_on_ff <= 1'h1;
         sweep_addr_ff <= (opc_ff == `EE_OPC_PROG) ? addr_ff : '0;
      end else if (busy) begin
         tmr_ff <= (tmr_ff == '0) ? tmr_ff : tmr_ff - TW'(1);
         sweep_on_ff <= sweep_on_ff & ~sweep_last;
         sweep_addr_ff <= sweep_addr_ff + ADDR_W'(1);
      end
   end

   // Erase-all stores all ones; data writes overwrite directly
   always_ff @(posedge clk_sys) begin
      if (wr_en_w) begin
         if (opc_ff == `EE_OPC_ERASE_ALL_CMD) begin
            mem_ff[sweep_addr_ff] <= '1; // [RULE14]
         end else begin
            mem_ff[sweep_addr_ff] <= wdata_ff; // [RULE12] [RULE13]
         end
      end
   end

   // Data out pin
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_out_ff <= 1'h0;
         oe_n_ff <= 1'h1;
      end else begin
         oe_n_ff <= ~(cs_s & (busy | ((st_ff == ST_IDLE) & verify_ff) |
                              ((st_ff == ST_READ) & nxt_rd_drive)));
         if (busy) begin
            data_out_ff <= 1'h0; // [RULE6]
         end else if (verify_ff && st_ff == ST_IDLE) begin
            data_out_ff <= 1'h1; // [RULE6] [RULE7]
         end else if (st_ff == ST_READ && sk_fall) begin
            data_out_ff <= rd_word[rbit_ff]; // [RULE1] [RULE23]
         end
      end
   end

   assign data_out = data_out_ff;
   assign data_out_oe_n = oe_n_ff;

   // Checks
   logic [TW-1:0] busy_len_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_len_ff <= '0;
      end else begin
         busy_len_ff <= busy ? busy_len_ff + TW'(1) : '0;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_write_launch;
      !busy ##1 busy;
   endsequence

   sequence s_word_end;
      (st_ff == ST_READ) && sk_fall && (rbit_ff == '0) && cs_s;
   endsequence

   chk_launch_needs_wel: assert property ( // [RULE15]
      s_write_launch |-> $past(wel_ff) && !$past(cs_s))
      else $error("write cycle started without enable latch");

   chk_busy_drives_low: assert property ( // [RULE6]
      busy && $past(busy) && $past(cs_s) |-> !data_out_oe_n && !data_out)
      else $error("data out not low while busy");

   chk_busy_length: assert property ( // [RULE5]
      busy |-> busy_len_ff < TW'(WRITE_CYCLES) &&
               32'(busy_len_ff) <= MAX_CYCLES)
      else $error("write cycle ran too long");

   chk_busy_ignores: assert property ( // [RULE8]
      busy && tmr_ff != '0 |=> busy && $stable(addr_ff) &&
                               $stable(opc_ff))
      else $error("command accepted during write cycle");

   chk_standby_idle: assert property ( // [RULE24]
      !cs_s && !busy && !launch |=> st_ff == ST_IDLE)
      else $error("not idle with chip select low");

   chk_start_hiz: assert property ( // [RULE9]
      start_seen |-> ##2 data_out_oe_n)
      else $error("start bit did not release data out");

   chk_start_needs_di: assert property ( // [RULE21]
      st_ff == ST_IDLE && sk_rise && !di_s && !launch |=>
         st_ff == ST_IDLE)
      else $error("start taken with data in low");

   chk_addr_wrap: assert property ( // [RULE3]
      s_word_end ##0 (&addr_ff) |=> addr_ff == '0)
      else $error("read address did not wrap to zero");

   chk_read_bit: assert property ( // [RULE1]
      (st_ff == ST_READ) && sk_fall |=> data_out == $past(rd_word[rbit_ff]))
      else $error("wrong read bit on data out");

   chk_protect_gate: assert property ( // [RULE18]
      busy && !prot_ff && !sweep_addr_ff[ADDR_W-1] |=>
         mem_ff[$past(sweep_addr_ff)] == $past(mem_ff[sweep_addr_ff]))
      else $error("write to protected half");

   chk_verify_after_write: assert property ( // [RULE22]
      $rose(verify_ff) |-> $past(launch))
      else $error("verify output armed without a write");
endmodule

/* test/eeprom_host.sv */
// Host model driving the serial EEPROM link
`timescale 1ns/1ps
module eeprom_host (
   input wire logic clk_sys,
   output logic chip_select,
   output logic serial_clock_in,
   output logic serial_data_in,
   output logic protect_in,
   input wire logic data_out,
   input wire logic data_out_oe_n
);
   int slow = 0;
   logic dout_seen;
   // A released output reads as the inverse of its last value
   assign dout_seen = data_out_oe_n ? ~data_out : data_out;
   initial begin
      chip_select = 1'b0;
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
      protect_in = 1'b0;
   end
   // One clock phase, stretched when the host runs slow
   task automatic half();
      repeat (4 + slow) @(posedge clk_sys);
   endtask
   // Data changes with the clock low and is taken at the rise
   task automatic put(input logic b);
      serial_clock_in <= 1'b0;
      serial_data_in <= b;
      half();
      serial_clock_in <= 1'b1;
      half();
   endtask
   // Output bit is sampled while the clock is high
   task automatic get(output logic b);
      put(1'b0);
      b = dout_seen;
   endtask
   // Pad zeros, start bit, opcode and address in two bytes
   task automatic frame(input logic [2:0] opc, input logic [7:0] adr);
      chip_select <= 1'b1;
      half();
      for (int i = 0; i < 4; i++) put(1'b0);
      put(1'b1);
      for (int i = 2; i >= 0; i--) put(opc[i]);
      for (int i = 7; i >= 0; i--) put(adr[i]);
   endtask
   task automatic words(input logic [31:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) put(d[i]);
   endtask
   // Clock parked low, then chip select low for the gap
   task automatic stop();
      serial_clock_in <= 1'b0;
      serial_data_in <= 1'b0;
      half();
      chip_select <= 1'b0;
      half();
      half();
   endtask
   // Completion check with data in held low
   task automatic poll_open();
      serial_data_in <= 1'b0;
      chip_select <= 1'b1;
      half();
      half();
   endtask
   task automatic set_prot(input logic p);
      protect_in <= p;
      half();
   endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the serial EEPROM command core
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module tb;
   localparam int WCYC = 400;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic chip_select, serial_clock_in, serial_data_in, protect_in;
   logic data_out, data_out_oe_n;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [15:0] mem [256];
   bit wel = 0;
   int a;
   always #12.5 clk_sys = ~clk_sys;
   serial_eeprom_command_core #(.WRITE_CYCLES(WCYC)) uut (
      .clk_sys(clk_sys), .rst(rst), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
      .protect_in(protect_in), .data_out(data_out),
      .data_out_oe_n(data_out_oe_n));
   eeprom_host host (
      .clk_sys(clk_sys), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
      .protect_in(protect_in), .data_out(data_out),
      .data_out_oe_n(data_out_oe_n));
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic cmp_word(input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected word at %0t: exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic cmp_pin(input logic [1:0] exp, input logic [1:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected pins at %0t: exp %h got %h", $time, exp, got);
      end
   endtask
   // Sequential read of n words, then a plain chip select raise
   task automatic rd(input int adr, input int n);
      logic b;
      logic [15:0] got;
      host.frame(`EE_OPC_READ, adr[7:0]);
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 16; i++) begin
            host.get(b);
            got = {got[14:0], b};
         end
         cmp_word(mem[(adr + k) % 256], got);
      end
      host.stop();
      host.poll_open();
      cmp_pin(2'b10, {data_out_oe_n, 1'b0});
      host.stop();
   endtask
   task automatic en(input bit on);
      host.frame(on ? `EE_OPC_PEN : `EE_OPC_PDS, 8'h00);
      host.stop();
      wel = on;
   endtask
   // Write command, model update, then completion check
   task automatic wr(input logic [2:0] opc, input int adr,
         input logic [31:0] d, input int nd, input bit ign);
      bit go;
      int t0;
      go = wel && (opc == `EE_OPC_ERASE_ALL_CMD || nd >= 16);
      host.frame(opc, adr[7:0]);
      host.words(d, nd);
      host.stop();
      t0 = cycles;
      for (int i = 0; i < 256 && go; i++) begin
         if ((protect_in || i[7]) && (opc != `EE_OPC_PROG || i == adr)) begin
            mem[i] = (opc == `EE_OPC_ERASE_ALL_CMD) ? 16'hFFFF : d[15:0];
         end
      end
      host.poll_open();
      cmp_pin(go ? 2'b00 : 2'b10,
         {data_out_oe_n, go ? data_out : 1'b0});
      if (go && ign) begin
         host.frame(`EE_OPC_PROG, adr[7:0] ^ 8'h01);
         host.words(32'h0000_1234, 16);
         host.stop();
         host.poll_open();
         cmp_pin(2'b00, {data_out_oe_n, data_out});
      end
      for (int t = 0; t < 1200 && go && data_out !== 1'b1; t++) begin
         @(posedge clk_sys);
      end
      if (go) begin
         cmp_pin(2'b01, {data_out_oe_n, data_out});
         t0 = cycles - t0;
         cmp_word(16'(t0 > WCYC - 20 && t0 < WCYC + 10),
            16'h1);
         host.put(1'b1);
         host.put(1'b0);
         cmp_pin(2'b10, {data_out_oe_n, 1'b0});
      end
      host.stop();
   endtask
   initial begin
      void'($urandom(73291));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      wr(`EE_OPC_ERASE_ALL_CMD, 0, 0, 0, 0);
      en(1);
      host.set_prot(1'b1);
      wr(`EE_OPC_ERASE_ALL_CMD, 0, 0, 0, 0);
      rd(8'hFE, 3);
      wr(`EE_OPC_WRITE_ALL_CMD, 9, $urandom, 16, 0);
      host.slow = 2;
      rd(8'h7E, 4);
      host.slow = 0;
      host.set_prot(1'b1);
      wr(`EE_OPC_WRITE_ALL_CMD, 0, $urandom, 18, 0);
      for (int k = 0; k < 8; k++) begin
         host.set_prot(1'($urandom));
         a = (k == 0) ? 8'h40 : $urandom % 256;
         wr(`EE_OPC_PROG, a, $urandom, 15 + $urandom % 6, k == 0);
         rd(a ^ 1, 2);
      end
      en(0);
      wr(`EE_OPC_PROG, 8'hFF, $urandom, 16, 0);
      rd(8'hFF, 2);
      test_done();
   end
endmodule
